// ### design/utc_timer_defs.vh
// Purpose: Constants for the up/down timer with compare/capture channels
// Assumes: Register word index times four gives the AXI byte address
// Notes: Included by utc_timer.v only
`ifndef UTC_TIMER_DEFS_VH
`define UTC_TIMER_DEFS_VH

// ------------------------------------
// Register word indices
// ------------------------------------
`define UTC_IDX_CTL 16'h2900
`define UTC_IDX_CNT 16'h2901
`define UTC_IDX_CCTL0 16'h2904
`define UTC_IDX_CCTL1 16'h2906
`define UTC_IDX_CCTL2 16'h2908
`define UTC_IDX_CCR0 16'h2910
`define UTC_IDX_CCR1 16'h2911
`define UTC_IDX_CCR2 16'h2912

// ------------------------------------
// Decoded register kinds
// ------------------------------------
`define UTC_SEL_NONE 3'h0
`define UTC_SEL_CTL 3'h1
`define UTC_SEL_CNT 3'h2
`define UTC_SEL_CCR 3'h3
`define UTC_SEL_CCTL 3'h4

// ------------------------------------
// Main control fields
// ------------------------------------
`define UTC_CTL_MODE_HI 5
`define UTC_CTL_MODE_LO 4
`define UTC_CTL_CLKSEL 3
`define UTC_CTL_CLR 2
`define UTC_CTL_WIE 1
`define UTC_CTL_WFLAG 0

// ------------------------------------
// Channel control fields
// ------------------------------------
`define UTC_CH_EDGE_HI 15
`define UTC_CH_EDGE_LO 14
`define UTC_CH_LATCH_EN 10
`define UTC_CH_IEN 4
`define UTC_CH_LEVEL 3
`define UTC_CH_FLAG 0

// ------------------------------------
// Modes, edges, values
// ------------------------------------
`define UTC_MODE_STOP 2'h0
`define UTC_MODE_UP 2'h1
`define UTC_MODE_CONT 2'h2
`define UTC_MODE_UPDN 2'h3
`define UTC_EDGE_OFF 2'h0
`define UTC_EDGE_RISE 2'h1
`define UTC_EDGE_FALL 2'h2
`define UTC_EDGE_BOTH 2'h3
`define UTC_RST16 16'h0000
`define UTC_MAX16 16'hFFFF
`define UTC_SLOW_DIV 8'h80
`define UTC_RESP_OKAY 2'h0
`define UTC_RESP_SLVERR 2'h2

`endif

// ### design/utc_timer.v
// Purpose: 16-bit timer, stop/up/continuous/up-down, three compare/capture
//          channels, AXI4-Lite register access
// Assumes: Single clock aclk, synchronous active-low reset aresetn
// Notes: Capture pins are synchronised by two flip-flops
//
// What this block does
// RULE_01 - Count when mode nonzero and clock tick active
// RULE_02 - Zero period halts counter in up modes
// RULE_03 - Nonzero period restarts upward from zero
// RULE_04 - Up: period at or above count applies now
// RULE_05 - Up: lower period applies after next wrap
// RULE_06 - Up/down: descending ignores rewrite until zero
// RULE_07 - Up/down: rising, higher period applies now
// RULE_08 - Up/down: rising, lower period waits full cycle
// RULE_09 - Enabled channel flag raises channel interrupt
// RULE_10 - Compare event sets channel flag bit zero
// RULE_11 - Software steps compare values for frequencies
// RULE_12 - Continuous wrap from maximum sets wrap flag
// RULE_13 - Edge field selects off/rise/fall/both capture
// RULE_14 - Latch input level at match when enabled
// RULE_15 - Match output whenever counter equals compare
// RULE_16 - Mode field: stop, up, continuous, up/down
// RULE_17 - Wrap flag on each mode's return to zero
// RULE_18 - Sixteen-bit registers, reserved bits read zero
`timescale 1ns/1ps
`include "utc_timer_defs.vh"

module utc_timer #(
   parameter [7:0] SLOW_DIV = `UTC_SLOW_DIV
) (
   input wire aclk,
   input wire aresetn,
   input wire [31:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [2:0] capture_pin,
   output reg [2:0] compare_match,
   output reg [2:0] chan_irq,
   output reg wrap_irq
);

   // ------------------------------------
   // Helper functions and declarations
   // ------------------------------------
   // Address decode: {channel, kind}
   function [4:0] dec;
      input [31:0] a;
      begin
         dec = {2'h0, `UTC_SEL_NONE};
         if (a[31:18] == 14'h0000 && a[1:0] == 2'h0) begin
            case (a[17:2])
               `UTC_IDX_CTL: dec = {2'h0, `UTC_SEL_CTL};
               `UTC_IDX_CNT: dec = {2'h0, `UTC_SEL_CNT};
               `UTC_IDX_CCR0: dec = {2'h0, `UTC_SEL_CCR};
               `UTC_IDX_CCR1: dec = {2'h1, `UTC_SEL_CCR};
               `UTC_IDX_CCR2: dec = {2'h2, `UTC_SEL_CCR};
               `UTC_IDX_CCTL0: dec = {2'h0, `UTC_SEL_CCTL};
               `UTC_IDX_CCTL1: dec = {2'h1, `UTC_SEL_CCTL};
               `UTC_IDX_CCTL2: dec = {2'h2, `UTC_SEL_CCTL};
               default: dec = {2'h0, `UTC_SEL_NONE};
            endcase
         end
      end
   endfunction

   // Byte-lane merge into a 16-bit register
   function [15:0] merge;
      input [15:0] old;
      input [15:0] d;
      input [1:0] s;
      begin
         merge[7:0] = s[0] ? d[7:0] : old[7:0];
         merge[15:8] = s[1] ? d[15:8] : old[15:8];
      end
   endfunction
   reg [31:0] awaddr_reg, wdata_reg; // Held write address and data
   reg [3:0] wstrb_reg; // Held strobes
   reg aw_full_reg, w_full_reg; // Address, data taken
   reg [1:0] mode_reg; // Counting mode
   reg clksel_reg; // 1: every clock, 0: slow tick
   reg clr_reg; // Clear request, one cycle
   reg wie_reg; // Wrap interrupt enable
   reg wflag_reg; // Wrap flag
   reg [15:0] cnt_reg; // Counter value
   reg dir_reg; // 0 up, 1 down
   reg [15:0] tgt_reg; // Period in effect
   reg [7:0] presc_reg; // Slow clock prescaler
   reg [15:0] ccr_reg [0:2]; // Compare/capture values
   reg [1:0] edge_reg [0:2]; // Capture edge select
   reg [2:0] latch_en_reg, ien_reg; // Latch at match, interrupt enable
   reg [2:0] level_reg, flag_reg; // Latched input level, channel flags
   reg [2:0] cap_s1_reg, cap_s2_reg, cap_d_reg; // Sync stages, previous level
   reg [15:0] cnt_next, tgt_next, per_now; // Next count, next target, period after write
   reg dir_next; // Next direction
   reg wrap_ev, load_ev; // Returned to zero, stepped
   integer k; // Channel index
   wire wr_fire; // Write executes
   wire [4:0] wsel, rsel; // Write and read decode
   wire tick; // Selected clock source active
   wire halt; // Zero period in up modes
   wire [2:0] ctl_wr, ccr_wr, cap_ev, cmp_ev; // Per-channel strobes and events

   assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   assign wsel = dec(awaddr_reg);
   assign rsel = dec(s_axi_araddr);
   assign tick = clksel_reg | (presc_reg == SLOW_DIV - 8'h01);
   // RULE_02 zero period halts
   assign halt = (mode_reg == `UTC_MODE_UP || mode_reg == `UTC_MODE_UPDN) &&
                 ccr_reg[0] == `UTC_RST16;

   // ------------------------------------
   // AXI4-Lite slave
   // ------------------------------------
   // Address and data taken in either order, response after both
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awaddr_reg <= 32'h00000000;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `UTC_RESP_OKAY;
      end else begin
         // Capture address
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_reg <= s_axi_awaddr;
            aw_full_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         // Capture data
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            w_full_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         // Execute and respond
         if (wr_fire) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel[2:0] == `UTC_SEL_NONE) ? `UTC_RESP_SLVERR :
                           `UTC_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end
   // One read at a time, data one cycle after address
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `UTC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `UTC_RESP_OKAY;
         // RULE_18 reserved bits zero
         case (rsel[2:0])
            `UTC_SEL_CTL: s_axi_rdata <= {26'h0000000, mode_reg, clksel_reg,
                                          1'b0, wie_reg, wflag_reg};
            `UTC_SEL_CNT: s_axi_rdata <= {16'h0000, cnt_reg};
            `UTC_SEL_CCR: s_axi_rdata <= {16'h0000, ccr_reg[rsel[4:3]]};
            `UTC_SEL_CCTL: s_axi_rdata <= {16'h0000, edge_reg[rsel[4:3]], 3'h0,
                                           latch_en_reg[rsel[4:3]], 5'h00,
                                           ien_reg[rsel[4:3]],
                                           level_reg[rsel[4:3]], 2'h0,
                                           flag_reg[rsel[4:3]]};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `UTC_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ------------------------------------
   // Main control register and prescaler
   // ------------------------------------
   // Mode, clock select, clear pulse, wrap flag
   always @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= `UTC_MODE_STOP;
         clksel_reg <= 1'b0;
         clr_reg <= 1'b0;
         wie_reg <= 1'b0;
         wflag_reg <= 1'b0;
         wrap_irq <= 1'b0;
      end else begin
         clr_reg <= 1'b0;
         if (wr_fire && wsel[2:0] == `UTC_SEL_CTL && wstrb_reg[0]) begin
            mode_reg <= wdata_reg[`UTC_CTL_MODE_HI:`UTC_CTL_MODE_LO];
            clksel_reg <= wdata_reg[`UTC_CTL_CLKSEL];
            clr_reg <= wdata_reg[`UTC_CTL_CLR];
            wie_reg <= wdata_reg[`UTC_CTL_WIE];
         end
         // RULE_12 wrap sets flag
         if (wrap_ev)
            wflag_reg <= 1'b1;
         else if (wr_fire && wsel[2:0] == `UTC_SEL_CTL && wstrb_reg[0] &&
                  wdata_reg[`UTC_CTL_WFLAG])
            wflag_reg <= 1'b0;
         wrap_irq <= wflag_reg & wie_reg;
      end
   end
   // Slow tick once per SLOW_DIV clocks
   always @(posedge aclk) begin
      if (!aresetn || clr_reg || tick)
         presc_reg <= 8'h00;
      else
         presc_reg <= presc_reg + 8'h01;
   end

   // ------------------------------------
   // Counter next state
   // ------------------------------------
   always @* begin
      cnt_next = cnt_reg;
      dir_next = dir_reg;
      tgt_next = tgt_reg;
      wrap_ev = 1'b0;
      load_ev = 1'b0;
      per_now = ccr_reg[0];
      // Period rewrite
      if (wr_fire && wsel == {2'h0, `UTC_SEL_CCR}) begin
         per_now = merge(ccr_reg[0], wdata_reg[15:0], wstrb_reg[1:0]);
         // RULE_04 RULE_07 higher period now
         // RULE_05 RULE_08 lower period deferred
         // RULE_06 descending keeps target
         if (!dir_reg && per_now >= cnt_reg)
            tgt_next = per_now;
      end
      if (clr_reg) begin
         cnt_next = `UTC_RST16;
         dir_next = 1'b0;
         tgt_next = per_now;
      end else if (halt) begin
         // RULE_03 restart from zero upward
         cnt_next = `UTC_RST16;
         dir_next = 1'b0;
      end else if (mode_reg != `UTC_MODE_STOP && tick) begin
         // RULE_01 run when mode and tick
         load_ev = 1'b1;
         // RULE_16 mode selection
         case (mode_reg)
            `UTC_MODE_UP: begin
               // RULE_17 wrap at period
               if (cnt_reg >= tgt_reg) begin
                  cnt_next = `UTC_RST16;
                  tgt_next = per_now;
                  wrap_ev = 1'b1;
               end else begin
                  cnt_next = cnt_reg + 16'h0001;
               end
            end
            `UTC_MODE_CONT: begin
               cnt_next = cnt_reg + 16'h0001;
               // RULE_12 RULE_17 wrap from maximum
               wrap_ev = (cnt_reg == `UTC_MAX16);
            end
            `UTC_MODE_UPDN: begin
               if (!dir_reg) begin
                  if (cnt_reg >= tgt_reg) begin
                     dir_next = 1'b1;
                     cnt_next = cnt_reg - 16'h0001;
                  end else begin
                     cnt_next = cnt_reg + 16'h0001;
                  end
               end else if (cnt_reg <= 16'h0001) begin
                  // RULE_17 one to zero step
                  cnt_next = `UTC_RST16;
                  dir_next = 1'b0;
                  tgt_next = per_now;
                  wrap_ev = (cnt_reg == 16'h0001);
               end else begin
                  cnt_next = cnt_reg - 16'h0001;
               end
            end
            default: cnt_next = cnt_reg;
         endcase
      end
   end

   // Counter registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= `UTC_RST16;
         dir_reg <= 1'b0;
         tgt_reg <= `UTC_RST16;
      end else begin
         cnt_reg <= cnt_next;
         dir_reg <= dir_next;
         tgt_reg <= tgt_next;
      end
   end

   // ------------------------------------
   // Compare/capture channels
   // ------------------------------------
   // Two flip-flops per pin, a third keeps the last level for edges
   always @(posedge aclk) begin
      if (!aresetn)
         {cap_d_reg, cap_s2_reg, cap_s1_reg} <= 9'h000;
      else
         {cap_d_reg, cap_s2_reg, cap_s1_reg} <= {cap_s2_reg, cap_s1_reg, capture_pin};
   end
   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_ch
         // Channel register writes
         assign ctl_wr[i] = wr_fire && wsel[4:3] == i && wsel[2:0] == `UTC_SEL_CCTL;
         assign ccr_wr[i] = wr_fire && wsel[4:3] == i && wsel[2:0] == `UTC_SEL_CCR;
         // RULE_13 edge selection
         assign cap_ev[i] = (edge_reg[i] == `UTC_EDGE_RISE && cap_s2_reg[i] && !cap_d_reg[i]) ||
                            (edge_reg[i] == `UTC_EDGE_FALL && !cap_s2_reg[i] && cap_d_reg[i]) ||
                            (edge_reg[i] == `UTC_EDGE_BOTH && cap_s2_reg[i] != cap_d_reg[i]);
         // Compare event only when the counter steps onto the value
         assign cmp_ev[i] = load_ev && edge_reg[i] == `UTC_EDGE_OFF &&
                            cnt_next == ccr_reg[i];
      end
   endgenerate
   // Channel registers; one process so each register has one driver
   always @(posedge aclk) begin
      if (!aresetn) begin
         for (k = 0; k < 3; k = k + 1) begin
            ccr_reg[k] <= `UTC_RST16;
            edge_reg[k] <= `UTC_EDGE_OFF;
         end
         latch_en_reg <= 3'h0;
         ien_reg <= 3'h0;
         level_reg <= 3'h0;
         flag_reg <= 3'h0;
         compare_match <= 3'h0;
         chan_irq <= 3'h0;
      end else begin
         for (k = 0; k < 3; k = k + 1) begin
            // Capture wins over software write
            if (cap_ev[k])
               ccr_reg[k] <= cnt_reg;
            else if (ccr_wr[k])
               ccr_reg[k] <= merge(ccr_reg[k], wdata_reg[15:0], wstrb_reg[1:0]);
            if (ctl_wr[k] && wstrb_reg[1]) begin
               edge_reg[k] <= wdata_reg[`UTC_CH_EDGE_HI:`UTC_CH_EDGE_LO];
               latch_en_reg[k] <= wdata_reg[`UTC_CH_LATCH_EN];
            end
            if (ctl_wr[k] && wstrb_reg[0])
               ien_reg[k] <= wdata_reg[`UTC_CH_IEN];
            // RULE_14 latch level at match
            if (latch_en_reg[k] && cmp_ev[k])
               level_reg[k] <= cap_s2_reg[k];
            // RULE_10 event sets flag
            if (cmp_ev[k] || cap_ev[k])
               flag_reg[k] <= 1'b1;
            else if (ctl_wr[k] && wstrb_reg[0] && wdata_reg[`UTC_CH_FLAG])
               flag_reg[k] <= 1'b0;
            // RULE_15 match level
            compare_match[k] <= (cnt_reg == ccr_reg[k]);
            // RULE_09 enabled flag to interrupt
            chan_irq[k] <= flag_reg[k] & ien_reg[k];
         end
      end
   end

endmodule // utc_timer

// ### verification/utc_timer_monitor.sv
// Purpose: Port checks for the timer's register bus and interrupt outputs
// Assumes: One clock aclk, synchronous active-low aresetn
// Notes: Bound to utc_timer at the foot of this file
`timescale 1ns/1ps

module utc_timer_monitor (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [2:0] chan_irq,
   input wire wrap_irq
);
   // ------------------------------------
   // Clock and reset for every check
   // ------------------------------------
   default clocking mon_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ------------------------------------
   // Register bus
   // ------------------------------------
   write_answer_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer not two edges after take");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one edge after take");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   rdata_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer dropped early");
   rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   ready_return_a: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready && !s_axi_bvalid)
      else $error("write channel not free after answer");

   // ------------------------------------
   // Reset and interrupt outputs
   // ------------------------------------
   reset_quiet_a: assert property (
      $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && chan_irq == 3'h0 && !wrap_irq)
      else $error("outputs not idle after reset");
   irq_drop_cause_a: assert property (
      ((|($past(chan_irq) & ~chan_irq)) || $fell(wrap_irq)) |->
      s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("interrupt fell without a register write");
endmodule // utc_timer_monitor

bind utc_timer utc_timer_monitor utc_timer_monitor_i (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .chan_irq(chan_irq), .wrap_irq(wrap_irq));

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the up/down timer over AXI4-Lite
// Assumes: Fast clock select, so one count per aclk
// Notes: Counter bounds and wrap flag reveal when a period takes effect
`timescale 1ns/1ps

module tb_top;
   // ------------------------------------
   // Addresses, signals, counters
   // ------------------------------------
   localparam logic [31:0] A_CTL = 32'h0000A400, A_CNT = 32'h0000A404, A_BAD = 32'h0000A4FC;
   localparam logic [31:0] A_CC0 = 32'h0000A410, A_CC1 = 32'h0000A418, A_CC2 = 32'h0000A420;
   localparam logic [31:0] A_PER = 32'h0000A440, A_CMP1 = 32'h0000A444;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wrap_irq;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [2:0] capture_pin, compare_match, chan_irq;
   logic [15:0] a;
   logic hit;
   int failures = 0, num_checks = 0, n, e;

   utc_timer #(.SLOW_DIV(8'h04)) utc_timer_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .capture_pin(capture_pin), .compare_match(compare_match),
      .chan_irq(chan_irq), .wrap_irq(wrap_irq));

   // ------------------------------------
   // Clock, compare, verdict
   // ------------------------------------
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic check(input string name, input logic [31:0] expv, input logic [31:0] got);
      num_checks++;
      if (got !== expv) begin
         failures++;
         $display("CHECK FAILED %s expected %h got %h", name, expv, got);
      end
   endtask

   task automatic summarize;
      if (failures == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ------------------------------------
   // Bus tasks; ready raised after valid, so answers are seen held
   // ------------------------------------
   task automatic wr(input logic [31:0] addr, input logic [15:0] d);
      s_axi_awaddr <= addr;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         s_axi_bready <= s_axi_bvalid;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] addr);
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         s_axi_rready <= s_axi_rvalid;
      end
      rv = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Poll the counter until it passes a threshold
   task automatic wait_above(input logic [15:0] th);
      int k;
      hit = 1'b0;
      for (k = 0; k < 400 && !hit; k++) begin
         rd(A_CNT);
         hit = (rv[15:0] > th);
      end
   endtask

   task automatic wait_irq(input int lim);
      for (n = 0; n < lim && wrap_irq !== 1'b1; n++) @(posedge aclk);
   endtask

   // Watchdog: a hang counts as a failure
   initial begin
      repeat (100000) @(posedge aclk);
      failures++;
      summarize();
   end

   // ------------------------------------
   // Test sequence
   // ------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, capture_pin} = 99'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // Reset values, read-only counter, unmapped place
      rd(A_CTL);
      check("ctl reset", 32'h0, rv);
      wr(A_CNT, 16'h1234);
      rd(A_CNT);
      check("counter read only", 32'h0, rv);
      rd(A_BAD);
      check("unmapped read", 32'h2, {rv[29:0], resp});
      wr(A_BAD, 16'hFFFF);
      check("unmapped write", 32'h2, {30'h0, resp});
      wr(A_CC1, 16'hFFFF);
      rd(A_CC1);
      check("reserved bits", 32'h0, rv & 32'hFFFF3BE6);
      // Up mode: match, channel flag and interrupt, bound, wrap flag
      wr(A_CC1, 16'h0010);
      wr(A_CMP1, 16'h0005);
      wr(A_PER, 16'h000A);
      wr(A_CTL, 16'h0018);
      for (n = 0; n < 200 && compare_match[1] !== 1'b1; n++) @(posedge aclk);
      check("match one", 32'h1, {31'h0, compare_match[1]});
      wr(A_CMP1, 16'h0008);
      repeat (30) @(posedge aclk);
      check("channel irqs", 32'h2, {29'h0, chan_irq});
      rd(A_CC1);
      check("channel flag", 32'h1, rv & 32'h1);
      for (n = 0; n < 6; n++) begin
         rd(A_CNT);
         check("up bound", 32'h1, {31'h0, rv[15:0] <= 16'h000A});
      end
      rd(A_CTL);
      check("up wrap flag", 32'h1, rv & 32'h1);
      // Latched input level at channel 0 match
      wr(A_CC0, 16'h0400);
      capture_pin[0] <= 1'b1;
      repeat (40) @(posedge aclk);
      rd(A_CC0);
      check("level high", 32'h8, rv & 32'h8);
      capture_pin[0] <= 1'b0;
      repeat (40) @(posedge aclk);
      rd(A_CC0);
      check("level low", 32'h0, rv & 32'h8);
      // Zero period halts, nonzero restarts from zero
      wr(A_PER, 16'h0000);
      repeat (5) @(posedge aclk);
      rd(A_CNT);
      check("halted", 32'h0, rv);
      wr(A_PER, 16'h00C8);
      rd(A_CNT);
      check("restart", 32'h1, {31'h0, rv[15:0] > 16'h0 && rv[15:0] < 16'h000C});
      // Up mode: lower period waits for the wrap, higher applies now
      wait_above(16'd120);
      wr(A_PER, 16'd50);
      rd(A_CNT);
      check("old period kept", 32'h1, {31'h0, rv[15:0] > 16'd50});
      repeat (300) @(posedge aclk);
      wait_above(16'd50);
      check("new period used", 32'h0, {31'h0, hit});
      wait_above(16'd30);
      wr(A_CTL, 16'h0019);
      wr(A_PER, 16'd150);
      wait_above(16'd60);
      rd(A_CTL);
      check("higher now", 32'h1, {31'h0, hit & ~rv[0]});
      // Up/down: rising higher, rising lower, falling rewrite
      wr(A_PER, 16'h0000);
      wr(A_CTL, 16'h0039);
      wr(A_PER, 16'd100);
      wait_above(16'd40);
      wr(A_PER, 16'd160);
      wait_above(16'd110);
      rd(A_CTL);
      check("updn climb", 32'h1, {31'h0, hit & ~rv[0]});
      wr(A_PER, 16'd60);
      rd(A_CNT);
      check("updn old top", 32'h1, {31'h0, rv[15:0] > 16'd110});
      repeat (300) @(posedge aclk);
      wait_above(16'd60);
      check("updn new top", 32'h0, {31'h0, hit});
      n = 0;
      do begin
         rd(A_CNT);
         a = rv[15:0];
         rd(A_CNT);
         n++;
      end while (!(rv[15:0] < a && rv[15:0] > 16'd30) && n < 100);
      wr(A_PER, 16'd200);
      wr(A_CTL, 16'h0039);
      wait_above(16'd60);
      rd(A_CTL);
      check("updn down first", 32'h1, {31'h0, hit & rv[0]});
      // Stop mode holds; capture edge selections
      wr(A_CTL, 16'h0008);
      rd(A_CNT);
      a = rv[15:0];
      repeat (10) @(posedge aclk);
      rd(A_CNT);
      check("stop holds", {16'h0, a}, rv);
      for (e = 0; e < 4; e++) begin
         wr(A_CC2, {e[1:0], 14'h0001});
         capture_pin[2] <= 1'b1;
         repeat (8) @(posedge aclk);
         rd(A_CC2);
         check("rise capture", {31'h0, e[0]}, rv & 32'h1);
         wr(A_CC2, {e[1:0], 14'h0001});
         capture_pin[2] <= 1'b0;
         repeat (8) @(posedge aclk);
         rd(A_CC2);
         check("fall capture", {31'h0, e[1]}, rv & 32'h1);
      end
      // Continuous mode wraps at the maximum
      wr(A_CTL, 16'h002F);
      wait_irq(70000);
      check("cont wrap", 32'h1, {31'h0, wrap_irq === 1'b1 && n > 65000});
      wr(A_CTL, 16'h0029);
      summarize();
   end
endmodule // tb_top
